// ==== hdl/pmbus_pkg.sv ====
// Constants, types and helper functions for the PMBus target front end
package pmbus_pkg;

    // Clock and strap sampling time
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int STRAP_SETTLE_US = 10;
    localparam int STRAP_SETTLE_CYC = STRAP_SETTLE_US * (CLK_FREQ_HZ / 1_000_000);

    // Strap code layout: two group bits over three offset bits
    localparam int STRAP_W = 5;
    localparam int STRAP_GRP_MSB = 4;
    localparam int STRAP_GRP_LSB = 3;
    localparam int STRAP_OFS_MSB = 2;

    // 7-bit base address of each strap group
    localparam logic [6:0] GRP0_BASE = 7'h40;
    localparam logic [6:0] GRP1_BASE = 7'h50;
    localparam logic [6:0] GRP2_BASE = 7'h58;
    localparam logic [6:0] GRP3_BASE = 7'h60;

    // Address byte layout and special addresses
    localparam int RW_BIT = 0;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [7:0] ARA_BYTE = 8'h19;

    // Command codes and page values
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] PAGE_OUT0 = 8'h00;
    localparam logic [7:0] PAGE_OUT1 = 8'h01;
    localparam logic [7:0] PAGE_BOTH = 8'hff;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [1:0] SEL_OUT0 = 2'h1;
    localparam logic [1:0] SEL_OUT1 = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    // Packet error check: CRC-8, polynomial x^8+x^2+x+1, zero seed
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'hff;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_SKIP
    } bus_state_t;

    // Strap code to 7-bit target address; every result lies in an accepted range
    function automatic logic [6:0] strap_to_addr(input logic [STRAP_W-1:0] code);
        logic [6:0] base;
        base = GRP0_BASE;
        unique case (code[STRAP_GRP_MSB:STRAP_GRP_LSB])
            2'h0: base = GRP0_BASE;
            2'h1: base = GRP1_BASE;
            2'h2: base = GRP2_BASE;
            2'h3: base = GRP3_BASE;
        endcase
        return base | {4'h0, code[STRAP_OFS_MSB:0]};
    endfunction

    // One byte through the CRC-8, msb first
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// ==== hdl/line_event_if.sv ====
// Synchronised bus line levels and edge events between the line sampler and the target
`timescale 1ns/1ps
interface line_event_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, output sda, output scl_rise, output scl_fall, output start_det, output stop_det);
    modport dst (input scl, input sda, input scl_rise, input scl_fall, input start_det, input stop_det);
endinterface

// ==== hdl/smbus_line_sync.sv ====
// Two-stage synchroniser and edge/condition detector for the serial clock and data lines
`timescale 1ns/1ps
module smbus_line_sync (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    line_event_if.src ev
);
    logic scl_meta_q, scl_sync_q, scl_prev_q;
    logic sda_meta_q, sda_sync_q, sda_prev_q;

    // Lines idle high, so reset to one to avoid a false start
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce_in) begin
            scl_meta_q <= scl_in;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
            sda_meta_q <= sda_in;
            sda_sync_q <= sda_meta_q;
            sda_prev_q <= sda_sync_q;
        end
    end

    // Events look only at the second and third stages
    assign ev.scl = scl_sync_q;
    assign ev.sda = sda_sync_q;
    assign ev.scl_rise = scl_sync_q & ~scl_prev_q;
    assign ev.scl_fall = ~scl_sync_q & scl_prev_q;
    assign ev.start_det = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
    assign ev.stop_det = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;
endmodule

// ==== hdl/pmbus_target.sv ====
// PMBus target front end: strapped address, command capture, page select, alert response, PEC
// Notes on behaviour
// - Own bus address comes from the strap pin code, captured after reset.
// - Besides the alert response address, only addresses 80-8E, A0-AE, B0-BE, C0-CE (8-bit form) are ever answered.
// - Address byte lsb selects direction: zero writes, one reads.
// - Any command code 00 through FF is taken after a write address.
// - Page 0 steers commands to output 0, page 1 to output 1.
// - The 7-bit address is the 8-bit write address shifted right once.
// - Framing follows PMBus 1.3 and SMBus 2.0.
// - With alert asserted, a read to address 0001_1001 returns our own address.
// - An optional trailing PEC byte with acknowledge ends a transaction.
// - Page command 00h selects output 0, 1 or both; page 0 after reset.
// - Clear-faults command 03h without data clears faults and releases alert.
// - Output overvoltage or undervoltage sets a fault and asserts the alert.
`timescale 1ns/1ps
module pmbus_target #(
    parameter int STRAP_SETTLE_CYCLES = pmbus_pkg::STRAP_SETTLE_CYC
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [pmbus_pkg::STRAP_W-1:0] address_strap_pin_in,
    input wire logic [1:0] ov_fault_in,
    input wire logic [1:0] uv_fault_in,
    input wire logic [7:0] rd_data_in,
    output logic bus_alert_out,
    output logic [1:0] page_sel_out,
    output logic [7:0] cmd_code_out,
    output logic cmd_strobe_out,
    output logic [6:0] own_addr_out,
    output logic addr_valid_out,
    output logic pec_error_out
);
    if (STRAP_SETTLE_CYCLES < 1 || STRAP_SETTLE_CYCLES > 65535) begin : g_bad_settle
        $error("STRAP_SETTLE_CYCLES must lie in 1..65535");
    end

    line_event_if ev ();

    smbus_line_sync u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    logic [pmbus_pkg::STRAP_W-1:0] strap_meta_q, strap_sync_q;
    logic [15:0] settle_cnt_q;
    logic [6:0] own_addr_q;
    logic addr_valid_q;
    pmbus_pkg::bus_state_t state_q, next_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shreg_q;
    logic [7:0] rx_byte;
    logic [7:0] tx_q, cmd_q, wdata_q, page_q, crc_q;
    logic [1:0] wr_cnt_q;
    logic cmd_seen_q, pec_match_q, sda_oe_q, first_tx_q;
    logic [3:0] fault_q;
    logic addr_hit, ara_hit, byte_done, pec_bad, commit_page, commit_clear, clear_now;
    logic [1:0] data_need;

    // Strap pin is a foreign level: two flops, then a settle count before capture
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
            settle_cnt_q <= 16'h0000;
            own_addr_q <= 7'h00;
            addr_valid_q <= 1'b0;
        end else if (ce_in) begin
            strap_meta_q <= address_strap_pin_in;
            strap_sync_q <= strap_meta_q;
            if (!addr_valid_q) begin
                if (settle_cnt_q == 16'(STRAP_SETTLE_CYCLES - 1)) begin
                    own_addr_q <= pmbus_pkg::strap_to_addr(strap_sync_q);
                    addr_valid_q <= 1'b1;
                end else begin
                    settle_cnt_q <= settle_cnt_q + 16'h0001;
                end
            end
        end
    end

    // Received byte and address decode
    assign rx_byte = {shreg_q, ev.sda};
    assign byte_done = ev.scl_rise && (bit_cnt_q == 3'h7);
    assign addr_hit = addr_valid_q && (rx_byte[7:1] == own_addr_q);
    assign ara_hit = (rx_byte == pmbus_pkg::ARA_BYTE) && bus_alert_out;

    // Stop-time commit: data bytes needed per command, one extra byte is PEC
    assign data_need = (cmd_q == pmbus_pkg::CMD_PAGE) ? 2'h1 : 2'h0;
    assign pec_bad = cmd_seen_q && (wr_cnt_q == data_need + 2'h1) && !pec_match_q;
    assign commit_page = ev.stop_det && cmd_seen_q && (cmd_q == pmbus_pkg::CMD_PAGE) &&
                         ((wr_cnt_q == 2'h1) || (wr_cnt_q == 2'h2 && pec_match_q));
    assign commit_clear = ev.stop_det && cmd_seen_q && (cmd_q == pmbus_pkg::CMD_CLEAR_FAULTS) &&
                          ((wr_cnt_q == 2'h0) || (wr_cnt_q == 2'h1 && pec_match_q));
    assign clear_now = ce_in && commit_clear;

    // Byte-level state machine; start and stop take priority over bit events
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= pmbus_pkg::ST_IDLE;
            next_q <= pmbus_pkg::ST_IDLE;
            bit_cnt_q <= 3'h0;
            shreg_q <= 7'h00;
            tx_q <= pmbus_pkg::FILL_BYTE;
            cmd_q <= 8'h00;
            wdata_q <= 8'h00;
            crc_q <= pmbus_pkg::CRC_SEED;
            wr_cnt_q <= 2'h0;
            cmd_seen_q <= 1'b0;
            pec_match_q <= 1'b0;
            sda_oe_q <= 1'b0;
            first_tx_q <= 1'b0;
        end else if (ce_in) begin
            if (ev.start_det) begin
                state_q <= pmbus_pkg::ST_ADDR;
                bit_cnt_q <= 3'h0;
                sda_oe_q <= 1'b0;
                if (state_q == pmbus_pkg::ST_IDLE || state_q == pmbus_pkg::ST_SKIP) begin
                    crc_q <= pmbus_pkg::CRC_SEED; // Repeated start keeps the running PEC
                end
            end else if (ev.stop_det) begin
                state_q <= pmbus_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
                cmd_seen_q <= 1'b0;
                wr_cnt_q <= 2'h0;
                crc_q <= pmbus_pkg::CRC_SEED;
            end else begin
                unique case (state_q)
                    pmbus_pkg::ST_IDLE, pmbus_pkg::ST_SKIP: begin
                        sda_oe_q <= 1'b0;
                    end
                    pmbus_pkg::ST_ADDR, pmbus_pkg::ST_CMD, pmbus_pkg::ST_WDATA: begin
                        if (ev.scl_rise) begin
                            shreg_q <= rx_byte[6:0];
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                        end
                        if (byte_done) begin
                            crc_q <= pmbus_pkg::crc8_step(crc_q, rx_byte);
                            state_q <= pmbus_pkg::ST_ACK;
                            if (state_q == pmbus_pkg::ST_ADDR) begin
                                if (!(addr_hit || ara_hit)) begin
                                    state_q <= pmbus_pkg::ST_SKIP;
                                end else if (rx_byte[pmbus_pkg::RW_BIT] == pmbus_pkg::RW_READ) begin
                                    next_q <= pmbus_pkg::ST_TX;
                                    first_tx_q <= 1'b1;
                                    if (ara_hit && !addr_hit) begin
                                        tx_q <= {own_addr_q, 1'b0};
                                    end else if (cmd_q == pmbus_pkg::CMD_PAGE) begin
                                        tx_q <= page_q;
                                    end else begin
                                        tx_q <= rd_data_in;
                                    end
                                end else begin
                                    next_q <= pmbus_pkg::ST_CMD;
                                    cmd_seen_q <= 1'b0;
                                    wr_cnt_q <= 2'h0;
                                end
                            end else if (state_q == pmbus_pkg::ST_CMD) begin
                                cmd_q <= rx_byte;
                                cmd_seen_q <= 1'b1;
                                next_q <= pmbus_pkg::ST_WDATA;
                            end else begin
                                if (wr_cnt_q == 2'h0) begin
                                    wdata_q <= rx_byte;
                                end
                                pec_match_q <= (rx_byte == crc_q);
                                if (wr_cnt_q != 2'h3) begin
                                    wr_cnt_q <= wr_cnt_q + 2'h1;
                                end
                                next_q <= pmbus_pkg::ST_WDATA;
                            end
                        end
                    end
                    pmbus_pkg::ST_ACK: begin
                        // First fall pulls the line low, second fall hands it on
                        if (ev.scl_fall) begin
                            if (!sda_oe_q) begin
                                sda_oe_q <= 1'b1;
                            end else begin
                                state_q <= next_q;
                                bit_cnt_q <= 3'h0;
                                sda_oe_q <= (next_q == pmbus_pkg::ST_TX) ? ~tx_q[7] : 1'b0;
                            end
                        end
                    end
                    pmbus_pkg::ST_TX: begin
                        if (ev.scl_rise) begin
                            if (!sda_oe_q && !ev.sda) begin
                                state_q <= pmbus_pkg::ST_SKIP; // Lost arbitration, withdraw
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 3'h1;
                                if (bit_cnt_q == 3'h7) begin
                                    crc_q <= pmbus_pkg::crc8_step(crc_q, tx_q);
                                    state_q <= pmbus_pkg::ST_TX_ACK;
                                end
                            end
                        end else if (ev.scl_fall) begin
                            sda_oe_q <= ~tx_q[3'h7 - bit_cnt_q];
                        end
                    end
                    pmbus_pkg::ST_TX_ACK: begin
                        if (ev.scl_fall) begin
                            sda_oe_q <= 1'b0;
                        end else if (ev.scl_rise) begin
                            if (ev.sda) begin
                                state_q <= pmbus_pkg::ST_SKIP; // Host ended the read
                            end else begin
                                state_q <= pmbus_pkg::ST_TX;
                                bit_cnt_q <= 3'h0;
                                first_tx_q <= 1'b0;
                                tx_q <= first_tx_q ? crc_q : pmbus_pkg::FILL_BYTE;
                            end
                        end
                    end
                    default: begin
                        state_q <= pmbus_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Page register, committed only at stop so a bad PEC can veto it
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            page_q <= pmbus_pkg::PAGE_RESET;
        end else if (ce_in && commit_page) begin
            if (wdata_q == pmbus_pkg::PAGE_OUT0 || wdata_q == pmbus_pkg::PAGE_OUT1 ||
                wdata_q == pmbus_pkg::PAGE_BOTH) begin
                page_q <= wdata_q;
            end
        end
    end

    // Sticky faults; a new fault in the clearing cycle survives the clear
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            fault_q <= 4'h0;
        end else if (ce_in) begin
            fault_q <= (clear_now ? 4'h0 : fault_q) | {uv_fault_in, ov_fault_in};
        end
    end

    // Command strobe and PEC error pulses
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cmd_strobe_out <= 1'b0;
            pec_error_out <= 1'b0;
        end else if (ce_in) begin
            cmd_strobe_out <= (state_q == pmbus_pkg::ST_CMD) && byte_done && !ev.start_det && !ev.stop_det;
            pec_error_out <= ev.stop_det && pec_bad;
        end else begin
            cmd_strobe_out <= 1'b0;
            pec_error_out <= 1'b0;
        end
    end

    // Page decode towards the output stages
    always_comb begin
        unique case (page_q)
            pmbus_pkg::PAGE_OUT1: page_sel_out = pmbus_pkg::SEL_OUT1;
            pmbus_pkg::PAGE_BOTH: page_sel_out = pmbus_pkg::SEL_BOTH;
            default: page_sel_out = pmbus_pkg::SEL_OUT0;
        endcase
    end

    // Open-drain data line: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_q;
    assign bus_alert_out = |fault_q;
    assign cmd_code_out = cmd_q;
    assign own_addr_out = own_addr_q;
    assign addr_valid_out = addr_valid_q;

    a_nack_foreign: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state_q == pmbus_pkg::ST_ADDR && byte_done && !ev.start_det && !ev.stop_det
         && !addr_hit && !ara_hit) |=> (state_q == pmbus_pkg::ST_SKIP) && !sda_oe_out)
        else $error("Foreign address was not left alone");

    a_skip_silent: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_q == pmbus_pkg::ST_SKIP) |-> !sda_oe_out)
        else $error("Data line driven while skipping");

    a_own_addr_range: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        addr_valid_out |-> (own_addr_out[6:3] == 4'h8 || own_addr_out[6:3] == 4'ha ||
                            own_addr_out[6:3] == 4'hb || own_addr_out[6:3] == 4'hc))
        else $error("Own address outside accepted set");

    a_strap_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(addr_valid_out) |-> own_addr_out == pmbus_pkg::strap_to_addr($past(strap_sync_q)))
        else $error("Own address differs from strap code");

    a_dir_split: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state_q == pmbus_pkg::ST_ADDR && byte_done && !ev.start_det && !ev.stop_det && addr_hit)
        |=> next_q == ($past(rx_byte[pmbus_pkg::RW_BIT]) ? pmbus_pkg::ST_TX : pmbus_pkg::ST_CMD))
        else $error("Direction bit not honoured");

    a_cmd_taken: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state_q == pmbus_pkg::ST_CMD && byte_done && !ev.start_det && !ev.stop_det)
        |=> cmd_strobe_out && cmd_code_out == $past(rx_byte))
        else $error("Command byte not captured");

    a_ara_reply: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && state_q == pmbus_pkg::ST_ADDR && byte_done && !ev.start_det && !ev.stop_det
         && ara_hit && !addr_hit) |=> tx_q == {own_addr_out, 1'b0})
        else $error("Alert response does not carry own address");

    a_page_commit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && commit_page && wdata_q == pmbus_pkg::PAGE_OUT1)
        |=> page_sel_out == pmbus_pkg::SEL_OUT1 ##1 (page_q == pmbus_pkg::PAGE_OUT1 || commit_page))
        else $error("Page write not applied");

    a_clear_alert: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (clear_now && ov_fault_in == 2'h0 && uv_fault_in == 2'h0) |=> !bus_alert_out)
        else $error("Clear faults left alert asserted");

    a_fault_alert: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && (|ov_fault_in || |uv_fault_in)) |=> bus_alert_out)
        else $error("Fault did not raise alert");

    a_pec_veto: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ce_in && ev.stop_det && pec_bad) |=> pec_error_out && $stable(page_q))
        else $error("Bad PEC not flagged or not vetoed");
endmodule

// ==== tb/smbus_host_model.sv ====
// Behavioural bus host: open-drain data, clock held high between frames
`timescale 1ns/1ps
module smbus_host_model (
    output logic scl_out,
    output logic sda_pull_out,
    input wire logic sda_line_in
);
    logic busy = 1'b0;
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    // One 160 ns slot; data moves only while the clock is low
    task automatic slot(input logic b, output logic seen);
        scl_out = 1'b0;
        #40 sda_pull_out = ~b;
        #40 scl_out = 1'b1;
        #40 seen = sda_line_in;
        #40;
    endtask
    // Start (data falls) or stop (data rises) while the clock is high
    task automatic cond(input logic is_start);
        if (busy) begin
            scl_out = 1'b0;
            #40 sda_pull_out = ~is_start;
            #40 scl_out = 1'b1;
        end
        #80 sda_pull_out = is_start;
        #80 busy = is_start;
    endtask
    // Byte out msb first, then the target's acknowledge slot
    task automatic put(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(d[i], s);
        slot(1'b1, nack);
    endtask
    // Byte in msb first; line released so the target can drive it
    task automatic get(input logic nack_in, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            d[i] = s;
        end
        slot(nack_in, s);
    endtask
endmodule

// ==== tb/pmbus_target_address_page_tb.sv ====
// Self-checking bench for the PMBus target front end
`timescale 1ns/1ps
module pmbus_target_address_page_tb;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [pmbus_pkg::STRAP_W-1:0] strap = 5'h00;
    logic [1:0] ov = 2'h0;
    logic [1:0] uv = 2'h0;
    logic scl, pull, sda_line, sda_out, sda_oe, alert, strobe, av, pec_err, nack_any, nack_all, pec_seen;
    logic [1:0] page_sel;
    logic [7:0] cmd_code, got, own8;
    logic [6:0] own;
    int error_cnt = 0;
    int n_tests = 0;
    int strobes = 0;
    logic ce = 1'b1;
    logic [7:0] rdd = 8'h3c;
    logic [11:0] rows [4] = '{{5'h00, pmbus_pkg::GRP0_BASE}, {5'h0a, pmbus_pkg::GRP1_BASE | 7'h2},
        {5'h17, pmbus_pkg::GRP2_BASE | 7'h7}, {5'h1d, pmbus_pkg::GRP3_BASE | 7'h5}};
    logic [9:0] pages [3] = '{{pmbus_pkg::PAGE_OUT1, pmbus_pkg::SEL_OUT1},
        {pmbus_pkg::PAGE_BOTH, pmbus_pkg::SEL_BOTH}, {pmbus_pkg::PAGE_OUT0, pmbus_pkg::SEL_OUT0}};
    // Pull-up wins unless one party sinks the line
    assign sda_line = ~(pull | (sda_oe & ~sda_out));
    initial forever #5 clock_in = ~clock_in;
    smbus_host_model i_smbus_host_model (.scl_out(scl), .sda_pull_out(pull), .sda_line_in(sda_line));
    pmbus_target #(.STRAP_SETTLE_CYCLES(4)) i_pmbus_target (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .ce_in(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
        .address_strap_pin_in(strap), .ov_fault_in(ov), .uv_fault_in(uv), .rd_data_in(rdd),
        .bus_alert_out(alert), .page_sel_out(page_sel), .cmd_code_out(cmd_code), .cmd_strobe_out(strobe),
        .own_addr_out(own), .addr_valid_out(av), .pec_error_out(pec_err));
    // One-cycle pulses are easy to miss, so latch or count them here
    always @(posedge clock_in) begin
        if (strobe === 1'b1) strobes++;
        if (pec_err === 1'b1) pec_seen = 1'b1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Packet check, poly x^8+x^2+x+1, zero seed, msb first
    function automatic logic [7:0] pec_of(input logic [7:0] b[$]);
        logic [7:0] c = 8'h00;
        foreach (b[j]) begin
            c ^= b[j];
            for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // Whole write frame; acknowledges gathered over every byte
    task automatic frame(input logic [7:0] b[$]);
        logic n;
        nack_any = 1'b0;
        nack_all = 1'b1;
        i_smbus_host_model.cond(1'b1);
        foreach (b[j]) begin
            i_smbus_host_model.put(b[j], n);
            nack_any |= n;
            nack_all &= n;
        end
        i_smbus_host_model.cond(1'b0);
    endtask
    // One-byte read, with or without a command phase before a repeated start
    task automatic rd(input logic [7:0] a, input logic [7:0] c, input logic with_cmd, output logic [7:0] d);
        logic n;
        i_smbus_host_model.cond(1'b1);
        if (with_cmd) begin
            i_smbus_host_model.put(a, n);
            i_smbus_host_model.put(c, n);
            i_smbus_host_model.cond(1'b1);
        end
        i_smbus_host_model.put(a | 8'h01, n);
        i_smbus_host_model.get(1'b1, d);
        i_smbus_host_model.cond(1'b0);
    endtask
    initial begin
        for (int r = 0; r < 4; r++) begin
            @(posedge clock_in) #1;
            strap = rows[r][11:7];
            rst_n_in = 1'b0;
            repeat (6) @(posedge clock_in);
            #1;
            check({6'h00, page_sel}, {6'h00, pmbus_pkg::SEL_OUT0});
            rst_n_in = 1'b1;
            for (int w = 0; w < 40 && av !== 1'b1; w++) @(posedge clock_in);
            check({1'b0, own}, {1'b0, rows[r][6:0]});
            check({7'h00, own[6:3] inside {4'h8, 4'ha, 4'hb, 4'hc}}, 8'h01);
        end
        own8 = {own, 1'b0};
        for (int k = 0; k < 3; k++) begin
            frame('{own8, pmbus_pkg::CMD_PAGE, pages[k][9:2]});
            check({7'h00, nack_any}, 8'h00);
            check({6'h00, page_sel}, {6'h00, pages[k][1:0]});
            rd(own8, pmbus_pkg::CMD_PAGE, 1'b1, got);
            check(got, pages[k][9:2]);
        end
        for (int k = 0; k < 2; k++) begin
            strobes = 0;
            frame('{own8, k ? 8'hff : 8'h5a});
            check(cmd_code, k ? 8'hff : 8'h5a);
            check(strobes[7:0], 8'h01);
        end
        // Any other command reads back whatever the data source offers
        rdd = 8'ha5;
        rd(own8, 8'h8b, 1'b1, got);
        check(got, 8'ha5);
        frame('{own8 ^ 8'h04, pmbus_pkg::CMD_PAGE, pmbus_pkg::PAGE_OUT1});
        check({7'h00, nack_all}, 8'h01);
        check({6'h00, page_sel}, {6'h00, pmbus_pkg::SEL_OUT0});
        pec_seen = 1'b0;
        frame('{own8, 8'h00, 8'h01, pec_of('{own8, 8'h00, 8'h01})});
        check({6'h00, page_sel, pec_seen}, {6'h00, pmbus_pkg::SEL_OUT1, 1'b0});
        frame('{own8, 8'h00, 8'h00, ~pec_of('{own8, 8'h00, 8'h00})});
        check({6'h00, page_sel, pec_seen}, {6'h00, pmbus_pkg::SEL_OUT1, 1'b1});
        // Enable low freezes the fault flags, so a one-cycle fault is not taken
        @(posedge clock_in) #1;
        {ce, ov} = 3'h1;
        @(posedge clock_in) #1;
        {ce, ov} = 3'h4;
        @(posedge clock_in) #1;
        check({7'h00, alert}, 8'h00);
        // Overvoltage then undervoltage, each answered on the alert address and cleared
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_in) #1;
            {ov, uv} = k ? 4'h2 : 4'h4;
            @(posedge clock_in) #1;
            {ov, uv} = 4'h0;
            @(posedge clock_in) #1;
            check({7'h00, alert}, 8'h01);
            rd(pmbus_pkg::ARA_BYTE, 8'h00, 1'b0, got);
            check(got, own8);
            frame('{own8, pmbus_pkg::CMD_CLEAR_FAULTS});
            check({7'h00, alert}, 8'h00);
        end
        conclude();
    end
    // Watchdog well beyond the expected run of under 150 us
    initial begin
        #400us;
        error_cnt++;
        conclude();
    end
endmodule
